// >>> qsp_pkg.sv
// constants, types and strap codes shared by the serial port
// assumes a single 40 MHz clock domain
package qsp_pkg;
  localparam logic [1:0] MODE_SINGLE_PLUS_PINS = 2'h0;
  localparam logic [1:0] MODE_THREE_STREAMS = 2'h1;
  localparam logic [1:0] MODE_FOUR_STREAMS = 2'h2;
  localparam logic [1:0] MODE_SINGLE_STREAM = 2'h3;
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_MASTER = 2'h1;
  localparam logic [1:0] FN_SLAVE = 2'h2;
  localparam logic [1:0] FN_TWI = 2'h3;
  localparam logic [1:0] WIDTH_SINGLE = 2'h0;
  localparam logic [1:0] WIDTH_DUAL = 2'h1;
  localparam logic [1:0] WIDTH_QUAD = 2'h2;
  localparam int CLK_HZ = 40000000;
  // guard and byte gap: six sck periods, counted in half periods
  localparam int GUARD_PERIODS = 6;
  localparam logic [4:0] GUARD_HALVES = 5'(2 * GUARD_PERIODS);
  localparam logic [4:0] HALVES_SINGLE = 5'h10;
  localparam logic [4:0] HALVES_DUAL = 5'h08;
  localparam logic [4:0] HALVES_QUAD = 5'h04;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef struct packed {
    logic cpol;
    logic cpha;
    logic [1:0] width;
    logic [2:0] div_log;
    logic [1:0] ss_sel;
  } qsp_cfg_type;
  typedef struct packed {
    logic write;
    logic last;
    logic [7:0] data;
  } qsp_cmd_type;
  typedef struct packed {
    logic [2:0] data_streams;
    logic pin_ctrl;
  } qsp_iface_type;
endpackage

// >>> qsp_port.sv
// serial port with strap-selected chip mode: master (1/2/4 lanes), slave, pin mux
// assumes straps stable after reset; pins resolved outside from out/oe pairs
// Behaviour
// - straps pick one of four modes
// - mode sets host interface counts
// - modes 01/10 force master, slave off
// - modes 00/11 enable at most one function (none for FN_NONE)
// - alternate-role pins ignore software pin control
// - host command chooses function and role
// - four active-low selects, 1-3 mapped by mode
// - lane mapping per transfer width
// - single duplex, dual and quad one-way
// - slave is single width full duplex
// - polarity sets idle clock level only
// - phase picks launch and sample edges
// - both ends share phase and polarity
// - phase and polarity change between transfers
// - each data line has one driver
// - select leads and trails by six periods
// - six idle periods between master bytes
// - slave takes bytes back to back
// - sck is clock over power of two
`timescale 1ns/1ps
module qsp_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic config_strap_hi,
  input wire logic config_strap_lo,
  input wire logic [1:0] fn_sel,
  input wire qsp_pkg::qsp_cfg_type cfg,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire qsp_pkg::qsp_cmd_type cmd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic busy,
  input wire logic [7:0] slv_tx_data,
  output logic slv_tx_take,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  input wire logic slave_select_in_n,
  output logic slave_select_out_0_n,
  input wire logic [3:0] sw_gp_out,
  input wire logic [3:0] sw_gp_oe,
  input wire logic twi_scl_low,
  input wire logic twi_sda_low,
  input wire logic suspend_indicator_out,
  output logic [3:0] gp_out,
  output logic [3:0] gp_oe,
  output logic [3:0] gp_sw_ignored,
  output logic [1:0] chip_mode,
  output qsp_pkg::qsp_iface_type iface,
  output logic master_en,
  output logic slave_en,
  output logic twi_en
);
  typedef enum logic [2:0] {M_IDLE, M_SETUP, M_SHIFT, M_GAP, M_HOLD} qsp_mstate_type;

  logic [1:0] strap_s1_ff, strap_s2_ff, strap_s3_ff;
  logic strap_done_ff;
  logic [2:0] strap_fill_ff;
  logic [1:0] mode_ff;
  logic multi_mode;
  qsp_mstate_type mst_ff;
  qsp_pkg::qsp_cfg_type fcfg_ff;
  logic write_ff, last_ff, sck_ff;
  logic [7:0] hcnt_ff, half_lim;
  logic [4:0] gcnt_ff, ecnt_ff, nhalves;
  logic [7:0] msr_ff, mrx_ff;
  logic [3:0] ss_ff;
  logic half_tick, guard_done, leading, m_sample, m_launch, take;
  logic [2:0] ss_s1_ff, ss_s2_ff, ss_s3_ff, ss_filt_ff;
  logic [7:0] ssr_ff, srx_ff;
  logic [2:0] sbit_ff;
  logic s_upd_sck, s_upd_ss, s_lead, s_sample, s_launch;
  logic [7:0] nxt_rx;

  // strap chain: caught once after reset release, when stages agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
      strap_s3_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap_fill_ff <= 3'h0;
      mode_ff <= qsp_pkg::MODE_SINGLE_PLUS_PINS;
    end else if (clk_en) begin
      strap_s1_ff <= {config_strap_hi, config_strap_lo};
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      // reset contents of the chain are not pin samples: wait until it has filled
      strap_fill_ff <= {strap_fill_ff[1:0], 1'b1};
      if (strap_fill_ff[2] && !strap_done_ff && strap_s2_ff == strap_s3_ff) begin
        mode_ff <= strap_s3_ff;
        strap_done_ff <= 1'b1;
      end
    end
  end

  assign chip_mode = mode_ff;
  assign multi_mode = mode_ff == qsp_pkg::MODE_THREE_STREAMS ||
                      mode_ff == qsp_pkg::MODE_FOUR_STREAMS;
  // the host picks the function; in multi-stream modes only master exists
  assign master_en = multi_mode || fn_sel == qsp_pkg::FN_MASTER;
  assign slave_en = !multi_mode && fn_sel == qsp_pkg::FN_SLAVE;
  assign twi_en = !multi_mode && fn_sel == qsp_pkg::FN_TWI;

  always_comb begin
    case (mode_ff)
      qsp_pkg::MODE_SINGLE_PLUS_PINS: iface = '{data_streams: 3'h1, pin_ctrl: 1'b1};
      qsp_pkg::MODE_THREE_STREAMS: iface = '{data_streams: 3'h3, pin_ctrl: 1'b1};
      qsp_pkg::MODE_FOUR_STREAMS: iface = '{data_streams: 3'h4, pin_ctrl: 1'b0};
      default: iface = '{data_streams: 3'h1, pin_ctrl: 1'b0};
    endcase
  end

  // master timing: half period is 2^div_log clocks, sck = mclk / 2^(div_log+1)
  assign half_lim = 8'((9'h1 << fcfg_ff.div_log) - 9'h1);
  assign half_tick = hcnt_ff == half_lim;
  assign guard_done = gcnt_ff == qsp_pkg::GUARD_HALVES;
  assign nhalves = fcfg_ff.width == qsp_pkg::WIDTH_QUAD ? qsp_pkg::HALVES_QUAD :
                   fcfg_ff.width == qsp_pkg::WIDTH_DUAL ? qsp_pkg::HALVES_DUAL :
                   qsp_pkg::HALVES_SINGLE;
  assign leading = !ecnt_ff[0];
  assign m_sample = half_tick && (leading ^ fcfg_ff.cpha);
  // cpha 1 launches on leading edges; the first bit is already on the line
  assign m_launch = half_tick && !(leading ^ fcfg_ff.cpha) &&
                    !(fcfg_ff.cpha && ecnt_ff == 5'h0);
  assign cmd_ready = master_en && (mst_ff == M_IDLE || (mst_ff == M_GAP && guard_done));
  assign take = cmd_ready && cmd_valid;
  assign busy = mst_ff != M_IDLE;

  always_comb begin
    case (fcfg_ff.width)
      qsp_pkg::WIDTH_QUAD: nxt_rx = {mrx_ff[3:0], lane_in};
      qsp_pkg::WIDTH_DUAL: nxt_rx = {mrx_ff[5:0], lane_in[1:0]};
      default: nxt_rx = {mrx_ff[6:0], lane_in[1]};
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mst_ff <= M_IDLE;
      fcfg_ff <= '0;
      write_ff <= 1'b0;
      last_ff <= 1'b0;
      sck_ff <= 1'b0;
      hcnt_ff <= 8'h0;
      gcnt_ff <= 5'h0;
      ecnt_ff <= 5'h0;
      msr_ff <= 8'h0;
      mrx_ff <= 8'h0;
      ss_ff <= 4'hF;
    end else if (clk_en) begin
      hcnt_ff <= half_tick ? 8'h0 : hcnt_ff + 8'h1;
      if (half_tick && !guard_done) begin
        gcnt_ff <= gcnt_ff + 5'h1;
      end
      if (take) begin
        msr_ff <= cmd.data;
        write_ff <= cmd.write;
        last_ff <= cmd.last;
        hcnt_ff <= 8'h0;
        gcnt_ff <= 5'h0;
        ecnt_ff <= 5'h0;
      end
      case (mst_ff)
        M_IDLE: begin
          sck_ff <= cfg.cpol;
          if (take) begin
            fcfg_ff <= cfg;
            sck_ff <= cfg.cpol;
            ss_ff <= ~(4'h1 << cfg.ss_sel);
            mst_ff <= M_SETUP;
          end
        end
        M_SETUP: begin
          if (guard_done) begin
            mst_ff <= M_SHIFT;
            hcnt_ff <= 8'h0;
          end
        end
        M_SHIFT: begin
          if (half_tick) begin
            sck_ff <= ~sck_ff;
            ecnt_ff <= ecnt_ff + 5'h1;
            if (ecnt_ff == nhalves - 5'h1) begin
              gcnt_ff <= 5'h0;
              mst_ff <= last_ff ? M_HOLD : M_GAP;
            end
          end
          if (m_sample) begin
            mrx_ff <= nxt_rx;
          end
          if (m_launch) begin
            case (fcfg_ff.width)
              qsp_pkg::WIDTH_QUAD: msr_ff <= {msr_ff[3:0], 4'h0};
              qsp_pkg::WIDTH_DUAL: msr_ff <= {msr_ff[5:0], 2'h0};
              default: msr_ff <= {msr_ff[6:0], 1'b0};
            endcase
          end
        end
        M_GAP: begin
          if (take) begin
            mst_ff <= M_SHIFT;
          end
        end
        M_HOLD: begin
          if (guard_done) begin
            ss_ff <= 4'hF;
            mst_ff <= M_IDLE;
          end
        end
        default: mst_ff <= M_IDLE;
      endcase
    end
  end

  // slave: sck, select and mosi pass three flops; an sck or select change counts once 2 and 3 agree
  assign s_upd_sck = ss_s2_ff[0] == ss_s3_ff[0] && ss_s3_ff[0] != ss_filt_ff[0];
  assign s_upd_ss = ss_s2_ff[1] == ss_s3_ff[1] && ss_s3_ff[1] != ss_filt_ff[1];
  assign s_lead = ss_s3_ff[0] != cfg.cpol;
  assign s_sample = slave_en && !ss_filt_ff[1] && s_upd_sck && (s_lead ^ cfg.cpha);
  assign s_launch = slave_en && !ss_filt_ff[1] && s_upd_sck && !(s_lead ^ cfg.cpha);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ss_s1_ff <= 3'h2;
      ss_s2_ff <= 3'h2;
      ss_s3_ff <= 3'h2;
      ss_filt_ff <= 3'h2;
    end else if (clk_en) begin
      ss_s1_ff <= {lane_in[0], slave_select_in_n, sck_in};
      ss_s2_ff <= ss_s1_ff;
      ss_s3_ff <= ss_s2_ff;
      if (s_upd_sck) begin
        ss_filt_ff[0] <= ss_s3_ff[0];
      end
      if (s_upd_ss) begin
        ss_filt_ff[1] <= ss_s3_ff[1];
      end
      ss_filt_ff[2] <= ss_s3_ff[2];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ssr_ff <= 8'h0;
      srx_ff <= 8'h0;
      sbit_ff <= 3'h0;
    end else if (clk_en) begin
      if (s_upd_ss && !ss_s3_ff[1]) begin
        sbit_ff <= 3'h0;
        ssr_ff <= slv_tx_data;
      end else begin
        if (s_sample) begin
          srx_ff <= {srx_ff[6:0], ss_s3_ff[2]};
          sbit_ff <= sbit_ff + 3'h1;
        end
        // next byte loads straight after the last bit, no gap needed
        if (s_launch) begin
          ssr_ff <= sbit_ff == 3'h0 ? slv_tx_data : {ssr_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign slv_tx_take = (s_upd_ss && !ss_s3_ff[1] && slave_en) ||
                       (s_launch && sbit_ff == 3'h0 && !s_upd_ss);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (mst_ff == M_SHIFT && half_tick && ecnt_ff == nhalves - 5'h1) begin
        rx_valid <= 1'b1;
        rx_data <= m_sample ? nxt_rx : mrx_ff;
      end else if (s_sample && sbit_ff == qsp_pkg::LAST_BIT && !s_upd_ss) begin
        rx_valid <= 1'b1;
        rx_data <= {srx_ff[6:0], ss_s3_ff[2]};
      end
    end
  end

  // lane drivers
  always_comb begin
    lane_out = 4'h0;
    lane_oe = 4'h0;
    if (slave_en) begin
      lane_out[1] = ssr_ff[7];
      lane_oe[1] = !ss_filt_ff[1];
    end else if (master_en && busy) begin
      case (fcfg_ff.width)
        qsp_pkg::WIDTH_QUAD: begin
          lane_out = msr_ff[7:4];
          lane_oe = {4{write_ff}};
        end
        qsp_pkg::WIDTH_DUAL: begin
          lane_out = {2'h0, msr_ff[7:6]};
          lane_oe = {2'h0, {2{write_ff}}};
        end
        default: begin
          lane_out = {3'h0, msr_ff[7]};
          lane_oe = 4'h1;
        end
      endcase
    end
  end

  assign sck_out = sck_ff;
  assign sck_oe = master_en;
  assign slave_select_out_0_n = ss_ff[0];

  // general pins, registered; software control ignored while in an alternate role
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gp_out <= 4'h0;
      gp_oe <= 4'h0;
      gp_sw_ignored <= 4'h0;
    end else if (clk_en) begin
      gp_out <= sw_gp_out;
      gp_oe <= sw_gp_oe;
      gp_sw_ignored <= 4'h0;
      if (multi_mode) begin
        gp_out[1:0] <= ss_ff[2:1];
        gp_oe[1:0] <= 2'h3;
        gp_sw_ignored[1:0] <= 2'h3;
      end else if (twi_en || mode_ff == qsp_pkg::MODE_SINGLE_STREAM) begin
        gp_out[1:0] <= 2'h0;
        gp_oe[1:0] <= {twi_sda_low && twi_en, twi_scl_low && twi_en};
        gp_sw_ignored[1:0] <= 2'h3;
      end
      if (mode_ff == qsp_pkg::MODE_FOUR_STREAMS) begin
        gp_out[2] <= ss_ff[3];
        gp_oe[2] <= 1'b1;
        gp_sw_ignored[3:2] <= 2'h3;
        gp_oe[3] <= 1'b0;
      end else if (mode_ff == qsp_pkg::MODE_SINGLE_STREAM) begin
        gp_out[2] <= suspend_indicator_out;
        gp_oe[2] <= 1'b1;
        gp_sw_ignored[3:2] <= 2'h3;
        gp_oe[3] <= 1'b0;
      end
    end
  end
endmodule

// >>> qsp_port_properties.sv
// concurrent checks on the qsp_port ports: modes, roles, selects, lanes
// assumes one clock domain and straps held steady between resets
`timescale 1ns/1ps
module qsp_port_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire qsp_pkg::qsp_cfg_type cfg,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic busy,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic [3:0] lane_oe,
  input wire logic slave_select_in_n,
  input wire logic slave_select_out_0_n,
  input wire logic [3:0] gp_sw_ignored,
  input wire logic [1:0] chip_mode,
  input wire qsp_pkg::qsp_iface_type iface,
  input wire logic master_en,
  input wire logic slave_en,
  input wire logic twi_en
);
  wire [3:0] exp_if = chip_mode == 2'h2 ? 4'h8 : {chip_mode == 2'h1 ? 3'h3 : 3'h1, ~chip_mode[1]};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_iface; iface == exp_if; endproperty
  a_iface: assert property (p_iface) else $error("iface count");
  property p_role; chip_mode inside {2'h1, 2'h2} |-> master_en && !slave_en && !twi_en; endproperty
  a_role: assert property (p_role) else $error("multi stream role");
  property p_onefn; $onehot0({master_en, slave_en, twi_en}); endproperty
  a_onefn: assert property (p_onefn) else $error("two functions on");
  property p_swig; (chip_mode == 2'h3) [*3] |-> gp_sw_ignored == 4'hF; endproperty
  a_swig: assert property (p_swig) else $error("pin control kept");
  property p_sckoe; sck_oe == master_en; endproperty
  a_sckoe: assert property (p_sckoe) else $error("sck driver");
  property p_sel; !slave_select_out_0_n |-> busy; endproperty
  a_sel: assert property (p_sel) else $error("select outside frame");
  property p_take;
    cmd_valid && cmd_ready && clk_en && master_en && !busy && cfg.ss_sel == 2'h0
      |=> !slave_select_out_0_n;
  endproperty
  a_take: assert property (p_take) else $error("select 0 late");
  property p_guard; $fell(slave_select_out_0_n) |-> ##1 (sck_out == cfg.cpol) [*7]; endproperty
  a_guard: assert property (p_guard) else $error("sck moved in setup");
  property p_slv; (slave_en && slave_select_in_n) [*5] |-> !lane_oe[1]; endproperty
  a_slv: assert property (p_slv) else $error("miso driven unselected");
endmodule
bind qsp_port qsp_port_properties u_props (.mclk(mclk), .rst(rst), .clk_en(clk_en),
  .cfg(cfg), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .busy(busy), .sck_out(sck_out),
  .sck_oe(sck_oe), .lane_oe(lane_oe), .slave_select_in_n(slave_select_in_n),
  .slave_select_out_0_n(slave_select_out_0_n), .gp_sw_ignored(gp_sw_ignored),
  .chip_mode(chip_mode), .iface(iface), .master_en(master_en), .slave_en(slave_en),
  .twi_en(twi_en));

// >>> qsp_slave_model.sv
// behavioural single-width slave on select 0 for the master tests
// assumes sck and mosi resolved by the bench; miso valid only while selected
`timescale 1ns/1ps
module qsp_slave_model (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  int k = 0;
  realtime t0 = 0;
  wire s = sck ^ cpol;
  // edges right after select ignored: idle level may settle late
  task automatic edge_in(input logic lead);
    if (ss_n || $realtime - t0 < 60.0) return;
    if (lead ^ cpha) begin
      sh = {sh[6:0], mosi};
      k = (k + 1) % 8;
      if (k == 0) rx = sh;
    end else begin
      miso = tx[7 - k];
    end
  endtask
  initial begin
    miso = 1'b0;
    rx = 8'h00;
  end
  always @(negedge ss_n) begin
    t0 = $realtime;
    k = 0;
    miso = tx[7];
  end
  always @(posedge ss_n) miso = ~miso;
  always @(posedge s) edge_in(1'b1);
  always @(negedge s) edge_in(1'b0);
endmodule

// >>> test_qsp_port.sv
// bench for qsp_port: strap modes, roles, master widths and formats, slave bytes
// assumes qsp_pkg, the slave model and the checker are compiled first
`timescale 1ns/1ps
module test_qsp_port;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [1:0] fn_sel = 2'h2;
  qsp_pkg::qsp_cfg_type cfg = '0;
  qsp_pkg::qsp_cmd_type cmd = '0;
  logic cmd_valid = 1'b0;
  logic tsck = 1'b0;
  logic tss_n = 1'b1;
  logic tmosi = 1'b0;
  logic [3:0] sw = 4'hA;
  logic [7:0] stx = 8'h5A;
  logic [7:0] rx_data, prx, got, sgot;
  logic [3:0] lane_out, lane_oe, gp_oe, gp_ign, gp_o;
  logic s_take;
  int n_take = 0;
  logic [7:0] eo [4] = '{8'hA, 8'hB, 8'hF, 8'h8};
  logic [1:0] chip_mode;
  logic [31:0] mon = '0;
  qsp_pkg::qsp_iface_type iface;
  logic cmd_ready, rx_valid, busy, sck_out, sck_oe, ss0_n, m_en, s_en, t_en, miso;
  int n_rx = 0;
  int n0 = 0;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] ei [4] = '{8'h3, 8'h7, 8'h8, 8'h2};
  logic [7:0] eg [4] = '{8'h0, 8'h3, 8'hF, 8'hF};
  localparam logic [15:0] SWORD = 16'h9669;
  wire sck = sck_oe ? sck_out : tsck;
  wire [3:0] lane_in = {~lane_out[3:2], lane_oe[1] ? lane_out[1] : miso,
    lane_oe[0] ? lane_out[0] : tmosi};
  qsp_port dut (.mclk(mclk), .rst(rst), .clk_en(1'b1), .config_strap_hi(strap[1]),
    .config_strap_lo(strap[0]), .fn_sel(fn_sel), .cfg(cfg), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy),
    .slv_tx_data(stx), .slv_tx_take(s_take), .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .slave_select_in_n(tss_n),
    .slave_select_out_0_n(ss0_n), .sw_gp_out(sw), .sw_gp_oe(sw), .twi_scl_low(1'b0),
    .twi_sda_low(1'b0), .suspend_indicator_out(1'b0), .gp_out(gp_o), .gp_oe(gp_oe),
    .gp_sw_ignored(gp_ign), .chip_mode(chip_mode), .iface(iface), .master_en(m_en),
    .slave_en(s_en), .twi_en(t_en));
  qsp_slave_model partner (.sck(sck), .ss_n(ss0_n), .mosi(lane_in[0]), .cpol(cfg.cpol),
    .cpha(cfg.cpha), .tx(stx), .miso(miso), .rx(prx));
  initial forever #12.5 mclk = ~mclk;
  always @(posedge sck_out) mon <= {mon[27:0], lane_out};
  always @(posedge mclk) begin
    if (s_take === 1'b1) n_take <= n_take + 1;
  end
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      got <= rx_data;
      n_rx <= n_rx + 1;
    end
  end
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic wait_for(input bit rx, input int k);
    int i;
    i = 0;
    while (rx ? n_rx < k : cmd_ready !== 1'b1) begin
      @(negedge mclk);
      i++;
      if (i > 3000) begin
        n_mismatch++;
        $display("BAD t=%0t no answer", $time);
        final_report();
      end
    end
  endtask
  task automatic do_reset(input logic [1:0] m);
    strap = m;
    rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
  endtask
  // f packs cpol, cpha, width and div_log; select 0 always
  task automatic mxfer(input logic [6:0] f, input logic l, input logic [7:0] d);
    cfg = {f, 2'h0};
    cmd = {1'b1, l, d};
    cmd_valid = 1'b1;
    wait_for(0, 0);
    @(negedge mclk);
    cmd_valid = 1'b0;
    wait_for(1, n_rx + 1);
  endtask
  // six clocks a half period leaves room for the select and edge filters
  task automatic sbit(input logic b);
    tmosi = b;
    repeat (6) @(negedge mclk);
    tsck = 1'b1;
    sgot = {sgot[6:0], lane_out[1]};
    repeat (6) @(negedge mclk);
    tsck = 1'b0;
  endtask
  initial begin
    do_reset(2'h0);
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      chk({6'h0, chip_mode}, 8'(m));
      chk({4'h0, iface}, ei[m]);
      chk({5'h0, m_en, s_en, t_en}, (m == 1 || m == 2) ? 8'h4 : 8'h2);
      chk({4'h0, gp_ign}, eg[m]);
      chk({4'h0, gp_o}, eo[m]);
    end
    do_reset(2'h0);
    for (int f = 0; f < 4; f++) begin
      fn_sel = f[1:0];
      repeat (2) @(negedge mclk);
      chk({5'h0, m_en, s_en, t_en}, 8'h8 >> (f == 0 ? 4 : f));
      chk({4'h0, gp_ign}, f == 3 ? 8'h3 : 8'h0);
    end
    chk({6'h0, gp_oe[3:2]}, 8'h2);
    fn_sel = qsp_pkg::FN_MASTER;
    // let cmd_ready follow the new role before the first handshake looks at it
    @(negedge mclk);
    for (int k = 0; k < 4; k++) begin
      stx = 8'hA5 ^ 8'(k);
      mxfer({k[1], k[0], qsp_pkg::WIDTH_SINGLE, k[2:0]}, 1'b1, 8'h3C + 8'(k));
      chk(got, stx);
      chk(prx, 8'h3C + 8'(k));
    end
    mxfer(7'h0, 1'b0, 8'h81);
    chk(prx, 8'h81);
    mxfer(7'h0, 1'b1, 8'h7E);
    chk(prx, 8'h7E);
    mxfer({2'h0, qsp_pkg::WIDTH_DUAL, 3'h0}, 1'b1, 8'hB4);
    chk({mon[13:12], mon[9:8], mon[5:4], mon[1:0]}, 8'hB4);
    mxfer({2'h0, qsp_pkg::WIDTH_QUAD, 3'h0}, 1'b1, 8'hD2);
    chk(mon[7:0], 8'hD2);
    fn_sel = qsp_pkg::FN_SLAVE;
    cfg = '0;
    stx = 8'h5A;
    repeat (20) @(negedge mclk);
    n0 = n_rx;
    tss_n = 1'b0;
    repeat (6) @(negedge mclk);
    for (int b = 0; b < 16; b++) begin
      sbit(SWORD[15 - b]);
      if (b == 7) begin
        chk(sgot, 8'h5A);
        chk(got, 8'h96);
      end
    end
    chk(sgot, 8'h5A);
    repeat (6) @(negedge mclk);
    tss_n = 1'b1;
    tmosi = ~tmosi;
    repeat (20) @(negedge mclk);
    chk(got, 8'h69);
    chk(8'(n_rx - n0), 8'h2);
    chk(8'(n_take), 8'h3);
    final_report();
  end
endmodule
